// ==== pkg/iei_pkg.sv ====
package iei_pkg;

  localparam int DIO_W = 16;
  localparam int N_AIN = 8;
  localparam int AIN_W = 16;
  localparam int STAT_W = 2;

  // Register byte offsets.
  localparam logic [7:0] OFF_CFG_STAGE = 8'h00;
  localparam logic [7:0] OFF_APPLY     = 8'h04;
  localparam logic [7:0] OFF_CFG_ACT   = 8'h08;
  localparam logic [7:0] OFF_DONE      = 8'h0c;
  localparam logic [7:0] OFF_STAT      = 8'h10;
  localparam logic [7:0] OFF_MASK      = 8'h14;
  localparam logic [7:0] OFF_FAST      = 8'h18;
  localparam logic [7:0] OFF_RT_IN     = 8'h1c;
  localparam logic [7:0] OFF_RT_OUT    = 8'h20;
  localparam logic [7:0] OFF_CYC_OUT   = 8'h24;
  localparam logic [7:0] OFF_CYC_IN    = 8'h28;
  localparam logic [7:0] OFF_ANA_BASE  = 8'h40;

  // Configuration word layout.
  localparam int CFG_CHAN_LSB = 0;
  localparam int CFG_MODE_LSB = 8;
  localparam int CFG_RD_BIT   = 16;
  localparam int CFG_WR_BIT   = 17;
  localparam int CFG_ANA_LSB  = 24;

  // Status bit positions.
  localparam int ST_TRIG_BIT    = 0;
  localparam int ST_OVERRUN_BIT = 1;

  // Reset values.
  localparam logic [31:0]     CFG_RST  = 32'h0000_0000;
  localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
  localparam logic [1:0]      FAST_RST = 2'h0;

  // Edge type codes and trigger channel count.
  localparam logic [7:0] EDGE_RISE     = 8'h01;
  localparam logic [7:0] EDGE_FALL     = 8'h02;
  localparam logic [7:0] EDGE_BOTH     = 8'h03;
  localparam logic [7:0] TRIG_CHANNELS = 8'h02;

  // Positions of the routine I/O in the digital words.
  localparam int RT_IO0_BIT = 0;
  localparam int RT_IO1_BIT = 8;
  localparam logic [DIO_W-1:0] RT_OUT_MASK = 16'h0101;

  typedef enum logic [1:0] {
    RT_IDLE,
    RT_SAMPLE,
    RT_RUN,
    RT_WRITE
  } iei_rt_state_t;

endpackage : iei_pkg

// ==== rtl/iei_edge_det.sv ====
`timescale 1ns/1ps
module iei_edge_det
  import iei_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] din,
  input  wire logic       sel,
  input  wire logic [7:0] mode,
  input  wire logic       flush,
  output logic            pulse
);

  logic [1:0] sync1_ff;
  logic [1:0] sync2_ff;
  logic       prev_ff;
  logic       pulse_ff;
  logic       flush_d_ff;
  logic       cur;
  logic       hit;

  function automatic logic edge_hit(input logic [7:0] m, input logic p, input logic c);
    logic rise;
    logic fall;
    rise = ~p & c;
    fall = p & ~c;
    unique case (m)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default:   edge_hit = 1'b0;
    endcase
  endfunction : edge_hit

  assign cur   = sync2_ff[sel];
  assign hit   = edge_hit(mode, prev_ff, cur);
  assign pulse = pulse_ff;

  // The history still holds the old channel for one cycle after a flush, so edges are
  // dropped in the flush cycle and the one after it to avoid a false edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_ff   <= 2'h0;
      sync2_ff   <= 2'h0;
      prev_ff    <= 1'b0;
      pulse_ff   <= 1'b0;
      flush_d_ff <= 1'b0;
    end else begin
      sync1_ff   <= din;
      sync2_ff   <= sync1_ff;
      prev_ff    <= cur;
      flush_d_ff <= flush;
      pulse_ff   <= hit & ~flush & ~flush_d_ff;
    end
  end

endmodule : iei_edge_det

// ==== rtl/iei_input_edge_irq.sv ====
`timescale 1ns/1ps
module iei_input_edge_irq
  import iei_pkg::*;
(
  input  wire logic                   CLOCK,
  input  wire logic                   NRST,
  input  wire logic                   PSEL,
  input  wire logic                   PENABLE,
  input  wire logic                   PWRITE,
  input  wire logic [7:0]             PADDR,
  input  wire logic [31:0]            PWDATA,
  output logic      [31:0]            PRDATA,
  output logic                        PREADY,
  output logic                        PSLVERR,
  input  wire logic [DIO_W-1:0]       DIN,
  input  wire logic [N_AIN*AIN_W-1:0] AIN_RAW,
  input  wire logic                   CYCLE_TICK,
  output logic      [DIO_W-1:0]       DOUT,
  output logic                        ISR_REQ,
  output logic                        IRQ
);

  logic [31:0]       cfg_stage_ff;
  logic [31:0]       cfg_act_ff;
  logic [STAT_W-1:0] stat_ff;
  logic [STAT_W-1:0] mask_ff;
  logic [1:0]        fast_ff;
  logic [1:0]        rt_in_ff;
  logic [1:0]        rt_out_ff;
  logic [DIO_W-1:0]  cyc_out_ff;
  logic [DIO_W-1:0]  cyc_in_ff;
  logic [DIO_W-1:0]  dout_ff;
  logic [31:0]       prdata_ff;
  logic [AIN_W-1:0]  analog_irq_raw_flags_ff [N_AIN];
  iei_rt_state_t     state_ff;
  iei_rt_state_t     nxt_state;

  // Bus decode.
  wire wr_en = PSEL & PENABLE & PWRITE;
  wire rd_setup = PSEL & ~PENABLE & ~PWRITE;
  wire hit_cfg = (PADDR == OFF_CFG_STAGE);
  wire hit_apply = (PADDR == OFF_APPLY);
  wire hit_act = (PADDR == OFF_CFG_ACT);
  wire hit_done = (PADDR == OFF_DONE);
  wire hit_stat = (PADDR == OFF_STAT);
  wire hit_mask = (PADDR == OFF_MASK);
  wire hit_fast = (PADDR == OFF_FAST);
  wire hit_rt_in = (PADDR == OFF_RT_IN);
  wire hit_rt_out = (PADDR == OFF_RT_OUT);
  wire hit_cyc_out = (PADDR == OFF_CYC_OUT);
  wire hit_cyc_in = (PADDR == OFF_CYC_IN);
  wire hit_ana = (PADDR[7:5] == OFF_ANA_BASE[7:5]) & (PADDR[1:0] == 2'h0);
  wire [2:0] ana_idx = PADDR[4:2];
  wire mapped = hit_cfg | hit_apply | hit_act | hit_done | hit_stat | hit_mask
              | hit_fast | hit_rt_in | hit_rt_out | hit_cyc_out | hit_cyc_in | hit_ana;

  // Applied configuration fields.
  wire [7:0] act_chan = cfg_act_ff[CFG_CHAN_LSB +: 8];
  wire [7:0] act_mode = cfg_act_ff[CFG_MODE_LSB +: 8];
  wire       act_rd = cfg_act_ff[CFG_RD_BIT];
  wire       act_wr = cfg_act_ff[CFG_WR_BIT];
  wire [7:0] act_ana = cfg_act_ff[CFG_ANA_LSB +: 8];

  // A one-cycle enable pulse is made from a write of one to the apply register.
  wire apply_pulse = wr_en & hit_apply & PWDATA[0];
  wire done_wr = wr_en & hit_done & PWDATA[0];

  wire chan_valid = (act_chan < TRIG_CHANNELS);
  wire chan_fast = fast_ff[act_chan[0]];
  wire edge_pulse;
  wire trig_ok = edge_pulse & chan_valid & chan_fast;
  wire busy = (state_ff != RT_IDLE);
  wire sampling = (state_ff == RT_SAMPLE);
  wire writing = (state_ff == RT_WRITE);

  wire [1:0] trig_pins = {DIN[RT_IO1_BIT], DIN[RT_IO0_BIT]};
  wire [1:0] trig_onehot = chan_valid ? (2'b01 << act_chan[0]) : 2'b00;
  wire [1:0] rt_in_new = trig_pins & ~trig_onehot;

  wire [STAT_W-1:0] stat_set;
  wire [STAT_W-1:0] stat_clr = (wr_en & hit_stat) ? PWDATA[STAT_W-1:0] : '0;
  wire [STAT_W-1:0] nxt_stat = (stat_ff & ~stat_clr) | stat_set;

  assign stat_set[ST_TRIG_BIT]    = trig_ok & ~busy;
  assign stat_set[ST_OVERRUN_BIT] = trig_ok & busy;

  // Routine outputs belong to the routine only while it is allowed to write them.
  wire [DIO_W-1:0] rt_own = act_wr ? RT_OUT_MASK : '0;
  wire [DIO_W-1:0] cyc_dout = (dout_ff & rt_own) | (cyc_out_ff & ~rt_own);
  wire [DIO_W-1:0] dout_base = CYCLE_TICK ? cyc_dout : dout_ff;
  wire [DIO_W-1:0] rt_dout = (DIO_W'(rt_out_ff[0]) << RT_IO0_BIT)
                           | (DIO_W'(rt_out_ff[1]) << RT_IO1_BIT);
  wire [DIO_W-1:0] nxt_dout = (writing && act_wr)
                            ? ((dout_base & ~RT_OUT_MASK) | rt_dout)
                            : dout_base;

  wire [31:0] rd_mux =
      hit_cfg     ? cfg_stage_ff :
      hit_act     ? cfg_act_ff :
      hit_done    ? 32'(busy) :
      hit_stat    ? 32'(stat_ff) :
      hit_mask    ? 32'(mask_ff) :
      hit_fast    ? 32'(fast_ff) :
      hit_rt_in   ? 32'(rt_in_ff) :
      hit_rt_out  ? 32'(rt_out_ff) :
      hit_cyc_out ? 32'(cyc_out_ff) :
      hit_cyc_in  ? 32'(cyc_in_ff) :
      hit_ana     ? 32'(analog_irq_raw_flags_ff[ana_idx]) :
                    32'h0000_0000;

  assign PRDATA  = prdata_ff;
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  assign DOUT    = dout_ff;
  assign ISR_REQ = sampling;
  assign IRQ     = |(stat_ff & mask_ff);

  iei_edge_det u_edge (
    .clk   (CLOCK),
    .rst_n (NRST),
    .din   (trig_pins),
    .sel   (act_chan[0]),
    .mode  (act_mode),
    .flush (apply_pulse),
    .pulse (edge_pulse)
  );

  // Routine sequencer: sample, let software run, then write outputs.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      RT_IDLE:   if (trig_ok) nxt_state = RT_SAMPLE;
      RT_SAMPLE: nxt_state = RT_RUN;
      RT_RUN:    if (done_wr) nxt_state = RT_WRITE;
      RT_WRITE:  nxt_state = RT_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      state_ff <= RT_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Staged and applied configuration.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      cfg_stage_ff <= CFG_RST;
      cfg_act_ff   <= CFG_RST;
    end else begin
      if (wr_en && hit_cfg) begin
        cfg_stage_ff <= PWDATA;
      end
      if (apply_pulse) begin
        cfg_act_ff <= cfg_stage_ff;
      end
    end
  end

  // Software owned control registers.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      mask_ff    <= MASK_RST;
      fast_ff    <= FAST_RST;
      rt_out_ff  <= 2'h0;
      cyc_out_ff <= '0;
    end else begin
      if (wr_en && hit_mask) begin
        mask_ff <= PWDATA[STAT_W-1:0];
      end
      if (wr_en && hit_fast) begin
        fast_ff <= PWDATA[1:0];
      end
      if (wr_en && hit_rt_out) begin
        rt_out_ff <= PWDATA[1:0];
      end
      if (wr_en && hit_cyc_out) begin
        cyc_out_ff <= PWDATA[DIO_W-1:0];
      end
    end
  end

  // Sticky status; a new event in the clearing cycle wins.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // Digital I/O of the regular cycle and of the routine.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      cyc_in_ff <= '0;
      rt_in_ff  <= 2'h0;
      dout_ff   <= '0;
    end else begin
      if (CYCLE_TICK) begin
        cyc_in_ff <= DIN;
      end
      if (sampling && act_rd) begin
        rt_in_ff <= rt_in_new;
      end
      dout_ff <= nxt_dout;
    end
  end

  // Analogue results for the selected channels.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      for (int n = 0; n < N_AIN; n++) begin
        analog_irq_raw_flags_ff[n] <= '0;
      end
    end else begin
      for (int n = 0; n < N_AIN; n++) begin
        if (sampling && act_ana[n]) begin
          analog_irq_raw_flags_ff[n] <= AIN_RAW[n*AIN_W +: AIN_W];
        end
      end
    end
  end

  // Read data is captured in the setup phase so the access phase ends at once.
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      prdata_ff <= '0;
    end else if (rd_setup) begin
      prdata_ff <= rd_mux;
    end
  end

endmodule : iei_input_edge_irq

// ==== tb/iei_input_edge_irq_asserts.sv ====
`timescale 1ns/1ps
module iei_input_edge_irq_asserts
  import iei_pkg::*;
(
  input wire logic             CLOCK,
  input wire logic             NRST,
  input wire logic             PSEL,
  input wire logic             PENABLE,
  input wire logic             PWRITE,
  input wire logic [7:0]       PADDR,
  input wire logic [31:0]      PWDATA,
  input wire logic [31:0]      PRDATA,
  input wire logic             PSLVERR,
  input wire logic [DIO_W-1:0] DIN,
  input wire logic             CYCLE_TICK,
  input wire logic [DIO_W-1:0] DOUT,
  input wire logic             ISR_REQ,
  input wire logic             IRQ
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // Counts quiet cycles on the two fast inputs; a routine start needs a recent change.
  logic [1:0] pins_ff;
  logic [3:0] quiet_ff;
  wire  [3:0] nxt_quiet = ({DIN[8], DIN[0]} != pins_ff) ? 4'h0 : quiet_ff + {3'h0, ~&quiet_ff};
  wire        acc       = PSEL && PENABLE;
  always_ff @(posedge CLOCK) begin
    if (!NRST) begin
      pins_ff  <= {DIN[8], DIN[0]};
      quiet_ff <= 4'hf;
    end else begin
      pins_ff  <= {DIN[8], DIN[0]};
      quiet_ff <= nxt_quiet;
    end
  end
  a_reset_quiet: assert property (disable iff (1'b0) !NRST |=> !ISR_REQ && !IRQ && DOUT == 16'h0)
    else $error("outputs active after reset");
  a_err_in_access: assert property (PSLVERR |-> acc) else $error("error outside access");
  a_err_unmapped: assert property (acc && PADDR == 8'h3c |-> PSLVERR) else $error("no error");
  a_read_holds: assert property (acc && !PWRITE |=> $stable(PRDATA)) else $error("read data moved");
  a_isr_spacing: assert property (ISR_REQ |=> !ISR_REQ [*3])
    else $error("routine restarted too soon");
  a_isr_needs_edge: assert property (ISR_REQ |-> quiet_ff < 4'h9)
    else $error("routine start without input edge");
  a_cycle_outputs: assert property ($changed(DOUT & ~RT_OUT_MASK) |-> $past(CYCLE_TICK))
    else $error("cycle output changed without tick");
  a_mask_clears: assert property (acc && PWRITE && PADDR == OFF_MASK && PWDATA[1:0] == 2'h0
    |-> ##2 !IRQ) else $error("interrupt stays high");
  c_routine: cover property (ISR_REQ);
  c_irq: cover property (IRQ);
  c_slverr: cover property (PSLVERR);
endmodule : iei_input_edge_irq_asserts

bind iei_input_edge_irq iei_input_edge_irq_asserts u_chk (.CLOCK, .NRST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PSLVERR, .DIN, .CYCLE_TICK, .DOUT, .ISR_REQ, .IRQ);

// ==== tb/iei_input_model.sv ====
`timescale 1ns/1ps
module iei_input_model
  import iei_pkg::*;
(
  input  wire logic [1:0]             pin,
  output logic      [DIO_W-1:0]       din,
  output logic      [N_AIN*AIN_W-1:0] ain_raw
);
  assign din = {7'h55, pin[1], 7'h2a, pin[0]};
  for (genvar n = 0; n < N_AIN; n++) begin : g_ain
    assign ain_raw[n*AIN_W +: AIN_W] = {8'ha5, 8'(n)};
  end
endmodule : iei_input_model

// ==== tb/test_input_edge_interrupt.sv ====
`timescale 1ns/1ps
module test_input_edge_interrupt
  import iei_pkg::*;
;
  logic         clock = 1'b0, nrst = 1'b0, tick = 1'b0;
  logic         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]   paddr = 8'h0;
  logic [31:0]  pwdata = 32'h0;
  logic [1:0]   pin = 2'h0;
  logic [31:0]  prdata, rdata;
  logic         pready, pslverr, err, isr, irq;
  logic [15:0]  din, dout;
  logic [127:0] ain;
  int           failures = 0, compares = 0, isr_cnt = 0, cycles = 0;
  initial forever #2 clock = ~clock;
  iei_input_edge_irq uut (.CLOCK(clock), .NRST(nrst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .DIN(din), .AIN_RAW(ain), .CYCLE_TICK(tick), .DOUT(dout),
    .ISR_REQ(isr), .IRQ(irq));
  iei_input_model u_in (.pin(pin), .din(din), .ain_raw(ain));
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask : rd
  task automatic cfg(input logic [31:0] v);
    xfer(1'b1, OFF_CFG_STAGE, v);
    xfer(1'b1, OFF_APPLY, 32'h1);
  endtask : cfg
  // Moves the input pins, counts routine starts, then ends any routine.
  task automatic edge_on(input logic [1:0] p, input int exp);
    int n;
    n = isr_cnt;
    @(posedge clock);
    pin <= p;
    repeat (10) @(posedge clock);
    chk(32'(isr_cnt - n), 32'(exp));
    xfer(1'b1, OFF_DONE, 32'h1);
  endtask : edge_on
  always @(posedge clock) begin
    cycles++;
    if (isr === 1'b1) isr_cnt++;
    if (cycles == 3000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(OFF_CFG_ACT, CFG_RST);
    rd(8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    xfer(1'b1, OFF_CFG_STAGE, 32'h0503_0300);
    rd(OFF_CFG_ACT, 32'h0);
    xfer(1'b1, OFF_APPLY, 32'h1);
    rd(OFF_CFG_ACT, 32'h0503_0300);
    edge_on(2'b01, 0);
    $display("test 1 done");
    xfer(1'b1, OFF_FAST, 32'h3);
    xfer(1'b1, OFF_RT_OUT, 32'h3);
    edge_on(2'b11, 0);
    edge_on(2'b10, 1);
    rd(OFF_RT_IN, 32'h2);
    rd(OFF_ANA_BASE, 32'h0000_a500);
    rd(OFF_ANA_BASE + 8'h04, 32'h0);
    rd(OFF_ANA_BASE + 8'h08, 32'h0000_a502);
    chk({30'h0, dout[8], dout[0]}, 32'h3);
    rd(OFF_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, OFF_MASK, 32'h1);
    rd(OFF_STAT, 32'h1);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, OFF_STAT, 32'h3);
    rd(OFF_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("test 2 done");
    xfer(1'b1, OFF_RT_OUT, 32'h0);
    edge_on(2'b00, 0);
    for (int m = 1; m < 4; m++) begin
      cfg({16'h0, 8'(m), 8'h0});
      edge_on(2'b01, int'(m != 2));
      edge_on(2'b00, int'(m != 1));
    end
    rd(OFF_RT_IN, 32'h2);
    chk({30'h0, dout[8], dout[0]}, 32'h3);
    xfer(1'b1, OFF_MASK, 32'h0);
    cfg(32'h0000_0302);
    edge_on(2'b01, 0);
    cfg(32'h0001_0101);
    edge_on(2'b11, 1);
    rd(OFF_RT_IN, 32'h1);
    xfer(1'b1, OFF_STAT, 32'h3);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      pin <= {k[0], 1'b1};
      repeat (8) @(posedge clock);
    end
    rd(OFF_DONE, 32'h1);
    rd(OFF_STAT, 32'h3);
    xfer(1'b1, OFF_DONE, 32'h1);
    rd(OFF_DONE, 32'h0);
    $display("test 3 done");
    xfer(1'b1, OFF_CYC_OUT, 32'hf0f0);
    chk({16'h0, dout}, 32'h0101);
    @(posedge clock);
    tick <= 1'b1;
    @(posedge clock);
    tick <= 1'b0;
    rd(OFF_CYC_IN, 32'h0000_ab55);
    chk({16'h0, dout}, 32'hf0f0);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(OFF_CFG_ACT, 32'h0);
    chk({16'h0, dout}, 32'h0);
    $display("test 4 done");
    conclude();
  end
endmodule : test_input_edge_interrupt
